// ==== hdl/host_pin_control.sv ====
// Implementation choices: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
// Notes on behaviour
// - the block makes no power-up reset of its own; it relies on hresetn from outside.
// - gp pins float after reset and drive low 140 ms after chip_reset_n rises.
// - the pulse outputs idle at the level of the pulse idle strap caught at reset.
// - the serial bit rate is 38.4 kbaud with the rate strap high, 19.2 kbaud low.
// - host_alert_n falls on end of frame and on alarm, each only while its bit is set in the mask register.
// - host_alert_n returns high when the host reads the status word.
// - conversion_frame_marker goes low at the start of each conversion cycle.
// - clock_out_disable in the mask register gates clock_test_out.
// - the serial port runs while serial_port_select_n is low; a high pulse resets it.
module host_pin_control #(
  parameter int RELEASE_TICKS_P = pin_ctrl_pkg::RELEASE_TICKS,
  parameter int CHIP_RST_CYC_P  = pin_ctrl_pkg::CHIP_RST_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        chip_reset_n,
  input  wire logic        pulse_idle_strap,
  input  wire logic        rate_strap,
  input  wire logic        serial_port_select_n,
  input  wire logic        clock_source,
  input  wire logic        pulse_third_in,
  input  wire logic        pulse_fourth_in,
  output logic      [7:0]  gp_pin_out,
  output logic      [7:0]  gp_pin_oe_n,
  output logic             pulse_out_third,
  output logic             pulse_out_fourth,
  output logic             host_alert_n,
  output logic             irq,
  output logic             conversion_frame_marker,
  output logic             clock_test_out,
  output logic             serial_port_enable,
  output logic             serial_port_reset,
  output logic      [15:0] baud_divisor
);
  import pin_ctrl_pkg::*;

  if (RELEASE_TICKS_P < 1 || RELEASE_TICKS_P > 65535) begin : g_bad_ticks
    $error("bad release ticks");
  end
  if (CHIP_RST_CYC_P < 1 || CHIP_RST_CYC_P > 255) begin : g_bad_width
    $error("bad reset width");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef enum logic [1:0] {
    GP_FLOAT = 2'b00,
    GP_WAIT  = 2'b01,
    GP_DRIVE = 2'b10
  } gp_state_t;

  typedef struct packed {
    logic                sync1;
    logic                sync2;
    logic [7:0]          low_cnt;
    logic                chip_rst;
    logic [9:0]          xdiv;
    logic                xtick;
    logic [15:0]         rel_cnt;
    gp_state_t           gp;
    logic                strap_done;
    logic                pulse_idle;
    logic                rate_fast;
    logic [ST_WIDTH-1:0] status;
    logic [8:0]          mask;
    logic [2:0]          control;
    logic                alert_n;
    logic                marker;
    logic                sel_d;
    logic                ph_act;
    logic                ph_wr;
    logic [7:0]          ph_addr;
    logic [31:0]         rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  logic                bus_req;
  logic                rd_status;
  logic [ST_WIDTH-1:0] events;
  logic [ST_WIDTH-1:0] clr;

  assign bus_req = hsel & hready & htrans[1];

  always_comb begin
    s_next = s_reg;
    rd_status = 1'b0;
    clr = '0;
    events = '0;
    // reset input synchroniser and width filter
    s_next.sync1 = chip_reset_n;
    s_next.sync2 = s_reg.sync1;
    if (!s_reg.sync2) begin
      if (s_reg.low_cnt != 8'(CHIP_RST_CYC_P)) begin
        s_next.low_cnt = s_reg.low_cnt + 8'h01;
      end else begin
        s_next.chip_rst = 1'b1;
      end
    end else begin
      s_next.low_cnt = 8'h00;
      s_next.chip_rst = 1'b0;
    end
    // crystal rate tick
    s_next.xtick = 1'b0;
    if (s_reg.xdiv == 10'(XTAL_DIV - 1)) begin
      s_next.xdiv = 10'h000;
      s_next.xtick = 1'b1;
    end else begin
      s_next.xdiv = s_reg.xdiv + 10'h001;
    end
    // gp pin release
    unique case (s_reg.gp)
      GP_FLOAT: begin
        s_next.rel_cnt = 16'h0000;
        if (s_reg.sync2) s_next.gp = GP_WAIT;
      end
      GP_WAIT: begin
        if (s_reg.xtick) begin
          s_next.rel_cnt = s_reg.rel_cnt + 16'h0001;
          if (s_reg.rel_cnt == 16'(RELEASE_TICKS_P - 1)) s_next.gp = GP_DRIVE;
        end
      end
      GP_DRIVE: ;
      default:  s_next.gp = GP_FLOAT;
    endcase
    if (s_reg.chip_rst || !s_reg.sync2) s_next.gp = GP_FLOAT;
    // straps caught after reset release
    if (!s_reg.strap_done) begin
      s_next.strap_done = 1'b1;
      s_next.pulse_idle = pulse_idle_strap;
      s_next.rate_fast = rate_strap;
    end
    if (s_reg.chip_rst) begin
      s_next.strap_done = 1'b0;
      s_next.pulse_idle = pulse_idle_strap;
      s_next.rate_fast = rate_strap;
    end
    // bus
    s_next.ph_act = bus_req;
    s_next.ph_wr = hwrite;
    s_next.ph_addr = haddr[7:0];
    if (bus_req && !hwrite) begin
      unique case (haddr[7:0])
        STATUS_OFF:  begin
          s_next.rdata = 32'(s_reg.status);
          rd_status = 1'b1;
        end
        MASK_OFF:    s_next.rdata = 32'(s_reg.mask);
        CONTROL_OFF: s_next.rdata = 32'(s_reg.control);
        STRAP_OFF:   s_next.rdata = {29'h0, s_reg.gp == GP_DRIVE, s_reg.rate_fast,
                                     s_reg.pulse_idle};
        default:     s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (s_reg.ph_act && s_reg.ph_wr) begin
      unique case (s_reg.ph_addr)
        STATUS_OFF:  clr = hwdata[ST_WIDTH-1:0];
        MASK_OFF:    s_next.mask = hwdata[8:0];
        CONTROL_OFF: s_next.control = hwdata[2:0];
        default: ;
      endcase
    end
    // events: frame end, alarm, conversion start pulse
    events[ST_FRAME_BIT] = s_reg.control[CTL_FRAME_BIT];
    events[ST_ALARM_BIT] = s_reg.control[CTL_ALARM_BIT];
    s_next.control[CTL_FRAME_BIT] = 1'b0;
    s_next.control[CTL_ALARM_BIT] = 1'b0;
    s_next.control[CTL_CONV_BIT] = 1'b0;
    if (s_reg.ph_act && s_reg.ph_wr && s_reg.ph_addr == CONTROL_OFF) begin
      s_next.control = hwdata[2:0];
    end
    s_next.status = (s_reg.status & ~clr) | events;
    // alert line
    if (|(events & s_reg.mask[ST_WIDTH-1:0])) begin
      s_next.alert_n = 1'b0;
    end else if (rd_status) begin
      s_next.alert_n = 1'b1;
    end
    s_next.marker = ~s_reg.control[CTL_CONV_BIT];
    s_next.sel_d = serial_port_select_n;
    if (s_reg.chip_rst) begin
      s_next.status = '0;
      s_next.mask = MASK_RESET;
      s_next.control = CONTROL_RESET;
      s_next.alert_n = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg <= '{gp: GP_FLOAT, mask: MASK_RESET, control: CONTROL_RESET, alert_n: 1'b1,
                 marker: 1'b1, sync2: 1'b1, sync1: 1'b1, pulse_idle: 1'b1,
                 default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign hrdata = s_reg.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign gp_pin_out = 8'h00;
  assign gp_pin_oe_n = (s_reg.gp == GP_DRIVE) ? 8'h00 : 8'hff;
  assign pulse_out_third = s_reg.strap_done ? pulse_third_in : s_reg.pulse_idle;
  assign pulse_out_fourth = s_reg.strap_done ? pulse_fourth_in : s_reg.pulse_idle;
  assign host_alert_n = s_reg.alert_n;
  assign irq = |(s_reg.status & s_reg.mask[ST_WIDTH-1:0]);
  assign conversion_frame_marker = s_reg.marker;
  assign clock_test_out = clock_source & ~s_reg.mask[CLKDIS_BIT];
  assign serial_port_enable = ~serial_port_select_n;
  assign serial_port_reset = s_reg.sel_d & ~serial_port_select_n;
  assign baud_divisor = s_reg.rate_fast ? 16'(DIV_FAST) : 16'(DIV_SLOW);

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_status_read;
    bus_req && !hwrite && haddr[7:0] == STATUS_OFF;
  endsequence

  property p_alert_fall;
    @(posedge hclk) disable iff (!hresetn)
      (|(events & s_reg.mask[ST_WIDTH-1:0])) && !s_reg.chip_rst |=> !host_alert_n;
  endproperty
  a_alert_fall: assert property (p_alert_fall) else $error("alert did not fall");

  property p_alert_rise;
    @(posedge hclk) disable iff (!hresetn)
      s_status_read ##0 !(|(events & s_reg.mask[ST_WIDTH-1:0])) |=> host_alert_n;
  endproperty
  a_alert_rise: assert property (p_alert_rise) else $error("alert did not rise");

  property p_float_low;
    @(posedge hclk) disable iff (!hresetn)
      !s_reg.sync2 |=> gp_pin_oe_n == 8'hff;
  endproperty
  a_float_low: assert property (p_float_low) else $error("gp driven in reset");

  property p_drive_tick;
    @(posedge hclk) disable iff (!hresetn)
      $rose(gp_pin_oe_n == 8'h00) |-> $past(s_reg.xtick) && gp_pin_out == 8'h00;
  endproperty
  a_drive_tick: assert property (p_drive_tick) else $error("gp release off tick");

  property p_clk_gate;
    @(posedge hclk) disable iff (!hresetn)
      s_reg.mask[CLKDIS_BIT] |-> !clock_test_out;
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("clock not gated");

  property p_marker;
    @(posedge hclk) disable iff (!hresetn)
      s_reg.control[CTL_CONV_BIT] |=> !conversion_frame_marker ##1 conversion_frame_marker;
  endproperty
  a_marker: assert property (p_marker) else $error("marker wrong");

  property p_baud;
    @(posedge hclk) disable iff (!hresetn)
      s_reg.strap_done |-> baud_divisor == (s_reg.rate_fast ? 16'(DIV_FAST) : 16'(DIV_SLOW));
  endproperty
  a_baud: assert property (p_baud) else $error("baud divisor wrong");

  property p_sel;
    @(posedge hclk) disable iff (!hresetn)
      $fell(serial_port_select_n) |-> serial_port_reset && serial_port_enable;
  endproperty
  a_sel: assert property (p_sel) else $error("serial port select wrong");

  property p_idle;
    @(posedge hclk) disable iff (!hresetn)
      !s_reg.strap_done |-> pulse_out_third == s_reg.pulse_idle &&
                            pulse_out_fourth == s_reg.pulse_idle;
  endproperty
  a_idle: assert property (p_idle) else $error("pulse idle wrong");

  property p_chip_rst;
    @(posedge hclk) disable iff (!hresetn)
      s_reg.chip_rst |=> host_alert_n && gp_pin_oe_n == 8'hff;
  endproperty
  a_chip_rst: assert property (p_chip_rst) else $error("chip reset ignored");
endmodule : host_pin_control

// ==== inc/pin_ctrl_pkg.sv ====
package pin_ctrl_pkg;
  // ----------------------------------------
  // bus map
  // ----------------------------------------
  localparam logic [7:0]  STATUS_OFF      = 8'h00;
  localparam logic [7:0]  MASK_OFF        = 8'h04;
  localparam logic [7:0]  CONTROL_OFF     = 8'h08;
  localparam logic [7:0]  STRAP_OFF       = 8'h0c;
  // status / mask bit positions
  localparam int          ST_FRAME_BIT    = 0;
  localparam int          ST_ALARM_BIT    = 1;
  localparam int          CLKDIS_BIT      = 8;
  localparam int          ST_WIDTH        = 2;
  localparam logic [8:0]  MASK_RESET      = 9'h003;
  // control bit positions
  localparam int          CTL_FRAME_BIT   = 0;
  localparam int          CTL_ALARM_BIT   = 1;
  localparam int          CTL_CONV_BIT    = 2;
  localparam logic [2:0]  CONTROL_RESET   = 3'h0;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int          CLK_HZ          = 25000000;
  localparam int          XTAL_HZ         = 32768;
  localparam int          CHIP_RST_MIN_US = 5;
  localparam int          CHIP_RST_CYC    = (CHIP_RST_MIN_US * CLK_HZ + 999999) / 1000000;
  localparam int          RELEASE_MS      = 140;
  localparam int          RELEASE_TICKS   = (RELEASE_MS * XTAL_HZ + 999) / 1000;
  localparam int          BAUD_FAST       = 38400;
  localparam int          BAUD_SLOW       = 19200;
  localparam int          DIV_FAST        = CLK_HZ / BAUD_FAST;
  localparam int          DIV_SLOW        = CLK_HZ / BAUD_SLOW;
  localparam int          XTAL_DIV        = CLK_HZ / XTAL_HZ;
endpackage : pin_ctrl_pkg

// ==== verif/host_model.sv ====
`timescale 1ns/1ps
module host_model (
  input  wire logic hclk,
  output logic      chip_reset_n,
  output logic      serial_port_select_n
);
  // ----------------------------------------
  // host side of reset and port select
  // ----------------------------------------
  initial begin
    chip_reset_n = 1'b1;
    serial_port_select_n = 1'b0;
  end

  task automatic hold_reset(input int cyc);
    @(posedge hclk);
    chip_reset_n <= 1'b0;
    repeat (cyc) @(posedge hclk);
    chip_reset_n <= 1'b1;
  endtask : hold_reset

  task automatic set_select(input logic v);
    @(posedge hclk);
    serial_port_select_n <= v;
  endtask : set_select
endmodule : host_model

// ==== verif/test_host_pin_control.sv ====
`timescale 1ns/1ps
module test_host_pin_control;
  import pin_ctrl_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, rd_phase;
  logic [31:0] haddr, hwdata, hrdata, seed, exp_q[$];
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        chip_reset_n, pulse_idle_strap, rate_strap, serial_port_select_n;
  logic        clock_source, pulse_third_in, pulse_fourth_in, host_alert_n, irq;
  logic [7:0]  gp_pin_out, gp_pin_oe_n;
  logic        pulse_out_third, pulse_out_fourth, conversion_frame_marker;
  logic        clock_test_out, serial_port_enable, serial_port_reset;
  logic [15:0] baud_divisor;
  int          miscompares = 0, cmp_count = 0, cycles = 0, n;

  localparam int SIM_TICKS = 3;
  host_pin_control #(.RELEASE_TICKS_P(SIM_TICKS), .CHIP_RST_CYC_P(2)) dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .chip_reset_n, .pulse_idle_strap, .rate_strap,
    .serial_port_select_n, .clock_source, .pulse_third_in, .pulse_fourth_in, .gp_pin_out,
    .gp_pin_oe_n, .pulse_out_third, .pulse_out_fourth, .host_alert_n, .irq,
    .conversion_frame_marker, .clock_test_out, .serial_port_enable, .serial_port_reset,
    .baud_divisor);
  host_model host (.hclk, .chip_reset_n, .serial_port_select_n);

  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // ----------------------------------------
  // random sources, timeout, read monitor
  // ----------------------------------------
  always @(posedge hclk) begin
    seed <= lfsr_next(seed);
    clock_source <= seed[0];
    pulse_third_in <= seed[1];
    pulse_fourth_in <= seed[2];
    cycles++;
    if (cycles == 30000) begin
      miscompares++;
      wrap_up();
    end
  end

  always @(posedge hclk) begin
    if (rd_phase === 1'b1 && hreadyout === 1'b1) begin
      check(hrdata, exp_q.pop_front());
      check({31'h0, hresp}, 32'h0);
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    rd_phase <= !wr;
    if (!wr) exp_q.push_back(d);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd_phase <= 1'b0;
  endtask : bus

  task automatic tick(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask : tick

  task automatic wait_release();
    int w;
    w = 0;
    check({24'h0, gp_pin_oe_n}, 32'hff);
    while (gp_pin_oe_n !== 8'h00 && w < 4000) begin
      @(posedge hclk);
      w++;
    end
    check(32'((w >= (SIM_TICKS - 1) * XTAL_DIV) && (w <= SIM_TICKS * XTAL_DIV + 16)), 32'h1);
    check({16'h0, gp_pin_oe_n, gp_pin_out}, 32'h0);
  endtask : wait_release

  task automatic chip_cycle(input logic idle, input logic rate);
    @(posedge hclk);
    pulse_idle_strap <= idle;
    rate_strap <= rate;
    host.hold_reset(CHIP_RST_CYC);
    check({30'h0, pulse_out_fourth, pulse_out_third}, {30'h0, idle, idle});
    wait_release();
    bus(0, STRAP_OFF, {29'h0, 1'b1, rate, idle});
    check({30'h0, pulse_out_fourth, pulse_out_third}, {30'h0, pulse_fourth_in, pulse_third_in});
    check({16'h0, baud_divisor}, rate ? DIV_FAST : DIV_SLOW);
  endtask : chip_cycle

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {hresetn, hsel, haddr, htrans, hwrite, hwdata, rd_phase} = '0;
    {clock_source, pulse_third_in, pulse_fourth_in} = 3'h0;
    {pulse_idle_strap, rate_strap, hsize, seed} = {2'b11, 3'b010, 32'he5b2};
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    tick(1);
    check({31'h0, host_alert_n}, 32'h1);
    wait_release();
    bus(0, MASK_OFF, 32'h3);
    bus(0, STATUS_OFF, 32'h0);
    bus(0, 8'h10, 32'h0);
    for (int b = 0; b < 2; b++) begin
      bus(1, CONTROL_OFF, 32'h1 << b);
      tick(3);
      check({30'h0, irq, host_alert_n}, 32'h2);
      bus(0, STATUS_OFF, 32'h1 << b);
      tick(2);
      check({31'h0, host_alert_n}, 32'h1);
      bus(1, STATUS_OFF, 32'h1 << b);
      bus(0, STATUS_OFF, 32'h0);
    end
    bus(1, MASK_OFF, 32'h0);
    bus(1, CONTROL_OFF, 32'h2);
    tick(4);
    check({30'h0, irq, host_alert_n}, 32'h1);
    bus(0, STATUS_OFF, 32'h2);
    bus(1, STATUS_OFF, 32'h2);
    bus(1, MASK_OFF, 32'h103);
    bus(0, MASK_OFF, 32'h103);
    repeat (8) begin
      tick(1);
      check({31'h0, clock_test_out}, 32'h0);
    end
    bus(1, MASK_OFF, 32'h3);
    tick(2);
    repeat (8) begin
      tick(1);
      check({31'h0, clock_test_out}, {31'h0, clock_source});
    end
    bus(1, CONTROL_OFF, 32'h4);
    n = 0;
    repeat (6) begin
      tick(1);
      n += int'(conversion_frame_marker === 1'b0);
    end
    check(n, 32'h1);
    host.set_select(1'b1);
    #1 check({30'h0, serial_port_enable, serial_port_reset}, 32'h0);
    host.set_select(1'b0);
    #1 check({30'h0, serial_port_enable, serial_port_reset}, 32'h3);
    tick(1);
    check({30'h0, serial_port_enable, serial_port_reset}, 32'h2);
    chip_cycle(1'b0, 1'b1);
    chip_cycle(1'b1, 1'b0);
    chip_cycle(seed[5], seed[6]);
    wrap_up();
  end
endmodule : test_host_pin_control
